/* File: rtl/mcr_metering_core_register_map.sv */
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module mcr_metering_core_register_map (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Indirect access writes from the microcontroller
	input wire logic pointer_wr,
	input wire logic data_low_wr,
	input wire logic data_mid_wr,
	input wire logic data_high_wr,
	input wire logic [7:0] sfr_wdata,
	// Indirect access readback
	output logic [7:0] indirect_pointer_byte,
	output logic [7:0] indirect_data_low,
	output logic [7:0] indirect_data_mid,
	output logic [7:0] indirect_data_high,
	output logic access_busy,
	// Measurement chain inputs
	input wire logic reactive_energy_valid,
	input wire logic [23:0] reactive_energy_inc,
	input wire logic apparent_energy_valid,
	input wire logic [23:0] apparent_energy_inc,
	input wire logic half_cycle_tick,
	input wire logic [15:0] line_period_meas,
	input wire logic [15:0] line_rate_meas,
	input wire logic current_peak_valid,
	input wire logic [23:0] current_peak_sample,
	input wire logic voltage_peak_valid,
	input wire logic [15:0] voltage_peak_sample,
	// Window end, for accumulators kept elsewhere
	output logic line_window_end,
	// Configuration towards the signal chain
	output logic [7:0] basic_config_one,
	output logic [7:0] basic_config_two,
	output logic [7:0] waveform_select_cfg,
	output logic [7:0] no_load_threshold_cfg,
	output logic [7:0] accumulation_cfg,
	output logic [7:0] phase_calibration,
	output logic [11:0] zero_cross_timeout,
	output logic [15:0] line_cycle_count,
	output logic [7:0] sag_half_cycle_count,
	output logic [15:0] sag_threshold,
	output logic [15:0] current_peak_threshold,
	output logic [15:0] voltage_peak_threshold,
	output logic [7:0] input_amp_gain,
	output logic [11:0] second_current_match_gain,
	output logic [11:0] active_power_gain,
	output logic [11:0] reactive_power_gain,
	output logic [11:0] apparent_power_gain,
	output logic [15:0] active_power_offset,
	output logic [15:0] reactive_power_offset,
	output logic [11:0] current_rms_offset,
	output logic [11:0] voltage_rms_offset,
	output logic [7:0] active_energy_divider,
	output logic [7:0] reactive_energy_divider,
	output logic [7:0] apparent_energy_divider,
	output logic [15:0] pulse_out1_numerator,
	output logic [15:0] pulse_out1_denominator,
	output logic [15:0] pulse_out2_numerator,
	output logic [15:0] pulse_out2_denominator,
	output logic [7:0] calibration_select
);

	////////////////////////////////////////////////////////////////////////////
	// Register layout decoding
	function automatic logic [15:0] cfg_mask(input logic [6:0] a);
		case (a)
			mcr_pkg::A_CFG_ONE, mcr_pkg::A_CFG_TWO, mcr_pkg::A_WAVE_SEL,
			mcr_pkg::A_NO_LOAD, mcr_pkg::A_ACCUM_CFG, mcr_pkg::A_PHASE_CAL,
			mcr_pkg::A_SAG_CYC, mcr_pkg::A_AMP_GAIN, mcr_pkg::A_ACT_DIV,
			mcr_pkg::A_REACT_DIV, mcr_pkg::A_APP_DIV, mcr_pkg::A_CAL_SEL:
				cfg_mask = mcr_pkg::MASK8;
			mcr_pkg::A_ZX_TIMEOUT, mcr_pkg::A_CUR2_GAIN, mcr_pkg::A_ACT_GAIN,
			mcr_pkg::A_REACT_GAIN, mcr_pkg::A_APP_GAIN, mcr_pkg::A_IRMS_OFS,
			mcr_pkg::A_VRMS_OFS:
				cfg_mask = mcr_pkg::MASK12;
			mcr_pkg::A_LINE_CYC, mcr_pkg::A_SAG_LVL, mcr_pkg::A_CUR_PK_LVL,
			mcr_pkg::A_VOLT_PK_LVL, mcr_pkg::A_ACT_OFS, mcr_pkg::A_REACT_OFS,
			mcr_pkg::A_PULSE1_NUM, mcr_pkg::A_PULSE1_DEN, mcr_pkg::A_PULSE2_NUM,
			mcr_pkg::A_PULSE2_DEN:
				cfg_mask = mcr_pkg::MASK16;
			default: cfg_mask = mcr_pkg::MASK_NONE;
		endcase
	endfunction

	function automatic logic [15:0] cfg_reset(input logic [6:0] a);
		case (a)
			mcr_pkg::A_CFG_ONE: cfg_reset = mcr_pkg::RST_CFG_ONE;
			mcr_pkg::A_CFG_TWO: cfg_reset = mcr_pkg::RST_CFG_TWO;
			mcr_pkg::A_PHASE_CAL: cfg_reset = mcr_pkg::RST_PHASE_CAL;
			mcr_pkg::A_ZX_TIMEOUT: cfg_reset = mcr_pkg::RST_ZX_TIMEOUT;
			mcr_pkg::A_LINE_CYC: cfg_reset = mcr_pkg::RST_LINE_CYC;
			mcr_pkg::A_SAG_CYC: cfg_reset = mcr_pkg::RST_SAG_CYC;
			mcr_pkg::A_CUR_PK_LVL: cfg_reset = mcr_pkg::RST_PK_LVL;
			mcr_pkg::A_VOLT_PK_LVL: cfg_reset = mcr_pkg::RST_PK_LVL;
			mcr_pkg::A_PULSE1_DEN: cfg_reset = mcr_pkg::RST_PULSE_DEN;
			mcr_pkg::A_PULSE2_DEN: cfg_reset = mcr_pkg::RST_PULSE_DEN;
			default: cfg_reset = mcr_pkg::RST_ZERO;
		endcase
	endfunction

	// Phase calibration stays zero-extended: one-byte reads must clear upper bytes
	function automatic logic cfg_signed(input logic [6:0] a);
		cfg_signed = (a >= mcr_pkg::A_CUR2_GAIN) && (a <= mcr_pkg::A_VRMS_OFS);
	endfunction

	function automatic logic [23:0] cfg_extend(input logic [6:0] a, input logic [15:0] v);
		logic [15:0] m;
		m = cfg_mask(a);
		if (cfg_signed(a) && m == mcr_pkg::MASK12) begin
			cfg_extend = {{12{v[mcr_pkg::W12-1]}}, v[mcr_pkg::W12-1:0]};
		end else if (cfg_signed(a) && m == mcr_pkg::MASK16) begin
			cfg_extend = {{8{v[mcr_pkg::W16-1]}}, v};
		end else begin
			cfg_extend = {8'h00, v & m};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State
	mcr_pkg::mcr_xfer_t state;
	mcr_pkg::mcr_xfer_t next_state;
	logic [15:0] cfg_mem [mcr_pkg::CFG_FIRST:mcr_pkg::CFG_LAST];
	logic [23:0] react_acc;
	logic [23:0] app_acc;
	logic [23:0] react_win;
	logic [23:0] app_win;
	logic [23:0] react_sync;
	logic [23:0] app_sync;
	logic [23:0] cur_peak;
	logic [15:0] volt_peak;
	logic [15:0] half_cnt;
	logic soft_rst;

	////////////////////////////////////////////////////////////////////////////
	// Transfer decode
	wire rst_all = sys_rst | soft_rst;
	wire xfer = (state == mcr_pkg::MCR_XFER);
	wire [6:0] xaddr = indirect_pointer_byte[mcr_pkg::ADDR_W-1:0];
	wire xfer_wr = xfer & indirect_pointer_byte[mcr_pkg::PTR_WRITE_BIT];
	wire xfer_rd = xfer & ~indirect_pointer_byte[mcr_pkg::PTR_WRITE_BIT];
	wire is_cfg = (xaddr >= 7'(mcr_pkg::CFG_FIRST)) && (xaddr <= 7'(mcr_pkg::CFG_LAST));
	wire [15:0] wr_mask = cfg_mask(xaddr);
	wire [15:0] wr_word = {indirect_data_mid, indirect_data_low} & wr_mask;
	wire swrst_hit = xfer_wr && xaddr == mcr_pkg::A_CFG_ONE
		&& indirect_data_low[mcr_pkg::SWRST_BIT];
	wire clr_react = xfer_rd && xaddr == mcr_pkg::A_REACT_ACC_CLR;
	wire clr_app = xfer_rd && xaddr == mcr_pkg::A_APP_ACC_CLR;
	wire clr_cur_pk = xfer_rd && xaddr == mcr_pkg::A_CUR_PEAK_CLR;
	wire clr_volt_pk = xfer_rd && xaddr == mcr_pkg::A_VOLT_PEAK_CLR;

	// Host must leave the access alone while it is in flight
	assign next_state = (state == mcr_pkg::MCR_IDLE && pointer_wr) ?
		mcr_pkg::MCR_XFER : mcr_pkg::MCR_IDLE;
	assign access_busy = xfer;

	////////////////////////////////////////////////////////////////////////////
	// Read selection
	wire [23:0] rd_cfg [mcr_pkg::CFG_FIRST:mcr_pkg::CFG_LAST];
	genvar g;
	generate
		for (g = mcr_pkg::CFG_FIRST; g <= mcr_pkg::CFG_LAST; g++) begin : g_rd
			assign rd_cfg[g] = cfg_extend(7'(g), cfg_mem[g]);
		end
	endgenerate

	wire freq_sel = basic_config_two[mcr_pkg::FREQSEL_BIT];
	wire [15:0] period_rate = freq_sel ? line_rate_meas : line_period_meas;
	wire is_react = xaddr == mcr_pkg::A_REACT_ACC || xaddr == mcr_pkg::A_REACT_ACC_CLR;
	wire is_app = xaddr == mcr_pkg::A_APP_ACC || xaddr == mcr_pkg::A_APP_ACC_CLR;
	wire is_cpk = xaddr == mcr_pkg::A_CUR_PEAK || xaddr == mcr_pkg::A_CUR_PEAK_CLR;
	wire is_vpk = xaddr == mcr_pkg::A_VOLT_PEAK || xaddr == mcr_pkg::A_VOLT_PEAK_CLR;
	wire [23:0] rd_word =
		is_react ? react_acc :
		is_app ? app_acc :
		(xaddr == mcr_pkg::A_REACT_SYNC) ? react_sync :
		(xaddr == mcr_pkg::A_APP_SYNC) ? app_sync :
		(xaddr == mcr_pkg::A_PERIOD_RATE) ? {8'h00, period_rate} :
		is_cpk ? cur_peak :
		is_vpk ? {8'h00, volt_peak} :
		is_cfg ? rd_cfg[xaddr] :
		24'h000000;

	////////////////////////////////////////////////////////////////////////////
	// Energy accumulation
	wire [23:0] react_term = reactive_energy_valid ? reactive_energy_inc : 24'h000000;
	wire [23:0] app_term = apparent_energy_valid ? apparent_energy_inc : 24'h000000;
	wire [23:0] react_acc_sum = react_acc + react_term;
	wire [23:0] app_acc_sum = app_acc + app_term;
	wire [23:0] react_win_sum = react_win + react_term;
	wire [23:0] app_win_sum = app_win + app_term;
	wire [15:0] next_half_cnt = half_cnt + 16'h0001;
	// A zero count closes a window on every half cycle
	wire window_end = half_cycle_tick && (next_half_cnt >= line_cycle_count);

	// An increment landing on the clearing read survives it
	always_ff @(posedge sys_clk) begin
		if (rst_all) begin
			react_acc <= 24'h000000;
			app_acc <= 24'h000000;
		end else begin
			react_acc <= clr_react ? react_term : react_acc_sum;
			app_acc <= clr_app ? app_term : app_acc_sum;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst_all) begin
			half_cnt <= 16'h0000;
			react_win <= 24'h000000;
			app_win <= 24'h000000;
			react_sync <= 24'h000000;
			app_sync <= 24'h000000;
			line_window_end <= 1'b0;
		end else begin
			line_window_end <= window_end;
			if (window_end) begin
				half_cnt <= 16'h0000;
				react_win <= 24'h000000;
				app_win <= 24'h000000;
				react_sync <= react_win_sum;
				app_sync <= app_win_sum;
			end else begin
				if (half_cycle_tick) begin
					half_cnt <= next_half_cnt;
				end
				react_win <= react_win_sum;
				app_win <= app_win_sum;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Peak capture
	wire cur_up = current_peak_valid && current_peak_sample > cur_peak;
	wire volt_up = voltage_peak_valid && voltage_peak_sample > volt_peak;
	wire [23:0] cur_fresh = current_peak_valid ? current_peak_sample : 24'h000000;
	wire [15:0] volt_fresh = voltage_peak_valid ? voltage_peak_sample : 16'h0000;

	always_ff @(posedge sys_clk) begin
		if (rst_all) begin
			cur_peak <= 24'h000000;
			volt_peak <= 16'h0000;
		end else begin
			if (clr_cur_pk) begin
				cur_peak <= cur_fresh;
			end else if (cur_up) begin
				cur_peak <= current_peak_sample;
			end
			if (clr_volt_pk) begin
				volt_peak <= volt_fresh;
			end else if (volt_up) begin
				volt_peak <= voltage_peak_sample;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration store; read-only and gap addresses carry an empty mask

	always_ff @(posedge sys_clk) begin
		if (rst_all) begin
			for (int i = mcr_pkg::CFG_FIRST; i <= mcr_pkg::CFG_LAST; i++) begin
				cfg_mem[i] <= cfg_reset(7'(i));
			end
		end else if (xfer_wr && is_cfg) begin
			cfg_mem[xaddr] <= wr_word;
		end
	end

	// Soft reset comes one cycle after the write and restores every default except the transfer state, pointer and data bytes
	always_ff @(posedge sys_clk) begin
		soft_rst <= !sys_rst && swrst_hit;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pointer and data bytes
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= mcr_pkg::MCR_IDLE;
			indirect_pointer_byte <= 8'h00;
			indirect_data_low <= 8'h00;
			indirect_data_mid <= 8'h00;
			indirect_data_high <= 8'h00;
		end else begin
			state <= next_state;
			if (xfer_rd) begin
				indirect_data_low <= rd_word[mcr_pkg::BYTE_W-1:0];
				indirect_data_mid <= rd_word[2*mcr_pkg::BYTE_W-1:mcr_pkg::BYTE_W];
				indirect_data_high <= rd_word[mcr_pkg::WORD_W-1:2*mcr_pkg::BYTE_W];
			end else if (!xfer) begin
				if (pointer_wr) begin
					indirect_pointer_byte <= sfr_wdata;
				end
				indirect_data_low <= data_low_wr ? sfr_wdata : indirect_data_low;
				indirect_data_mid <= data_mid_wr ? sfr_wdata : indirect_data_mid;
				indirect_data_high <= data_high_wr ? sfr_wdata : indirect_data_high;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration outputs
	assign basic_config_one = cfg_mem[mcr_pkg::A_CFG_ONE][7:0];
	assign basic_config_two = cfg_mem[mcr_pkg::A_CFG_TWO][7:0];
	assign waveform_select_cfg = cfg_mem[mcr_pkg::A_WAVE_SEL][7:0];
	assign no_load_threshold_cfg = cfg_mem[mcr_pkg::A_NO_LOAD][7:0];
	assign accumulation_cfg = cfg_mem[mcr_pkg::A_ACCUM_CFG][7:0];
	assign phase_calibration = cfg_mem[mcr_pkg::A_PHASE_CAL][7:0];
	assign zero_cross_timeout = cfg_mem[mcr_pkg::A_ZX_TIMEOUT][11:0];
	assign line_cycle_count = cfg_mem[mcr_pkg::A_LINE_CYC];
	assign sag_half_cycle_count = cfg_mem[mcr_pkg::A_SAG_CYC][7:0];
	assign sag_threshold = cfg_mem[mcr_pkg::A_SAG_LVL];
	assign current_peak_threshold = cfg_mem[mcr_pkg::A_CUR_PK_LVL];
	assign voltage_peak_threshold = cfg_mem[mcr_pkg::A_VOLT_PK_LVL];
	assign input_amp_gain = cfg_mem[mcr_pkg::A_AMP_GAIN][7:0];
	assign second_current_match_gain = cfg_mem[mcr_pkg::A_CUR2_GAIN][11:0];
	assign active_power_gain = cfg_mem[mcr_pkg::A_ACT_GAIN][11:0];
	assign reactive_power_gain = cfg_mem[mcr_pkg::A_REACT_GAIN][11:0];
	assign apparent_power_gain = cfg_mem[mcr_pkg::A_APP_GAIN][11:0];
	assign active_power_offset = cfg_mem[mcr_pkg::A_ACT_OFS];
	assign reactive_power_offset = cfg_mem[mcr_pkg::A_REACT_OFS];
	assign current_rms_offset = cfg_mem[mcr_pkg::A_IRMS_OFS][11:0];
	assign voltage_rms_offset = cfg_mem[mcr_pkg::A_VRMS_OFS][11:0];
	assign active_energy_divider = cfg_mem[mcr_pkg::A_ACT_DIV][7:0];
	assign reactive_energy_divider = cfg_mem[mcr_pkg::A_REACT_DIV][7:0];
	assign apparent_energy_divider = cfg_mem[mcr_pkg::A_APP_DIV][7:0];
	assign pulse_out1_numerator = cfg_mem[mcr_pkg::A_PULSE1_NUM];
	assign pulse_out1_denominator = cfg_mem[mcr_pkg::A_PULSE1_DEN];
	assign pulse_out2_numerator = cfg_mem[mcr_pkg::A_PULSE2_NUM];
	assign pulse_out2_denominator = cfg_mem[mcr_pkg::A_PULSE2_DEN];
	assign calibration_select = cfg_mem[mcr_pkg::A_CAL_SEL][7:0];

endmodule

/* File: rtl/mcr_pkg.sv */
package mcr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Pointer byte and data byte layout
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned WORD_W = 24;
	localparam int unsigned CFG_W = 16;
	localparam int unsigned PTR_WRITE_BIT = 7;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned SWRST_BIT = 7;
	localparam int unsigned FREQSEL_BIT = 1;
	localparam int unsigned W12 = 12;
	localparam int unsigned W16 = 16;

	////////////////////////////////////////////////////////////////////////////
	// Internal register addresses
	localparam logic [6:0] A_REACT_ACC = 7'h04;
	localparam logic [6:0] A_REACT_ACC_CLR = 7'h05;
	localparam logic [6:0] A_REACT_SYNC = 7'h06;
	localparam logic [6:0] A_APP_ACC = 7'h07;
	localparam logic [6:0] A_APP_ACC_CLR = 7'h08;
	localparam logic [6:0] A_APP_SYNC = 7'h09;
	localparam logic [6:0] A_PERIOD_RATE = 7'h0A;
	localparam logic [6:0] A_CFG_ONE = 7'h0B;
	localparam logic [6:0] A_CFG_TWO = 7'h0C;
	localparam logic [6:0] A_WAVE_SEL = 7'h0D;
	localparam logic [6:0] A_NO_LOAD = 7'h0E;
	localparam logic [6:0] A_ACCUM_CFG = 7'h0F;
	localparam logic [6:0] A_PHASE_CAL = 7'h10;
	localparam logic [6:0] A_ZX_TIMEOUT = 7'h11;
	localparam logic [6:0] A_LINE_CYC = 7'h12;
	localparam logic [6:0] A_SAG_CYC = 7'h13;
	localparam logic [6:0] A_SAG_LVL = 7'h14;
	localparam logic [6:0] A_CUR_PK_LVL = 7'h15;
	localparam logic [6:0] A_VOLT_PK_LVL = 7'h16;
	localparam logic [6:0] A_CUR_PEAK = 7'h17;
	localparam logic [6:0] A_CUR_PEAK_CLR = 7'h18;
	localparam logic [6:0] A_VOLT_PEAK = 7'h19;
	localparam logic [6:0] A_VOLT_PEAK_CLR = 7'h1A;
	localparam logic [6:0] A_AMP_GAIN = 7'h1B;
	localparam logic [6:0] A_CUR2_GAIN = 7'h1C;
	localparam logic [6:0] A_ACT_GAIN = 7'h1D;
	localparam logic [6:0] A_REACT_GAIN = 7'h1E;
	localparam logic [6:0] A_APP_GAIN = 7'h1F;
	localparam logic [6:0] A_ACT_OFS = 7'h20;
	localparam logic [6:0] A_REACT_OFS = 7'h21;
	localparam logic [6:0] A_IRMS_OFS = 7'h22;
	localparam logic [6:0] A_VRMS_OFS = 7'h23;
	localparam logic [6:0] A_ACT_DIV = 7'h24;
	localparam logic [6:0] A_REACT_DIV = 7'h25;
	localparam logic [6:0] A_APP_DIV = 7'h26;
	localparam logic [6:0] A_PULSE1_NUM = 7'h27;
	localparam logic [6:0] A_PULSE1_DEN = 7'h28;
	localparam logic [6:0] A_PULSE2_NUM = 7'h29;
	localparam logic [6:0] A_PULSE2_DEN = 7'h2A;
	localparam logic [6:0] A_CAL_SEL = 7'h3D;
	localparam int unsigned CFG_FIRST = 11;
	localparam int unsigned CFG_LAST = 61;

	////////////////////////////////////////////////////////////////////////////
	// Write masks and reset values
	localparam logic [15:0] MASK_NONE = 16'h0000;
	localparam logic [15:0] MASK8 = 16'h00FF;
	localparam logic [15:0] MASK12 = 16'h0FFF;
	localparam logic [15:0] MASK16 = 16'hFFFF;
	localparam logic [15:0] RST_CFG_ONE = 16'h0006;
	localparam logic [15:0] RST_CFG_TWO = 16'h0040;
	localparam logic [15:0] RST_PHASE_CAL = 16'h0040;
	localparam logic [15:0] RST_ZX_TIMEOUT = 16'h0FFF;
	localparam logic [15:0] RST_LINE_CYC = 16'hFFFF;
	localparam logic [15:0] RST_SAG_CYC = 16'h00FF;
	localparam logic [15:0] RST_PK_LVL = 16'hFFFF;
	localparam logic [15:0] RST_PULSE_DEN = 16'h003F;
	localparam logic [15:0] RST_ZERO = 16'h0000;

	typedef enum logic {MCR_IDLE, MCR_XFER} mcr_xfer_t;

endpackage

/* File: sim/mcr_host_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module mcr_host_model (
	// Clock
	input wire logic sys_clk,
	// Data bytes read back
	input wire logic [7:0] indirect_data_low,
	input wire logic [7:0] indirect_data_mid,
	input wire logic [7:0] indirect_data_high,
	// Register writes towards the core
	output logic pointer_wr,
	output logic data_low_wr,
	output logic data_mid_wr,
	output logic data_high_wr,
	output logic [7:0] sfr_wdata
);
	initial {pointer_wr, data_low_wr, data_mid_wr, data_high_wr, sfr_wdata} = 12'h000;
	// Data bytes first, pointer last, one strobe per cycle
	task automatic access(input logic [7:0] ptr, input logic [23:0] d, output logic [23:0] rd);
		@(negedge sys_clk);
		{data_low_wr, sfr_wdata} = {1'b1, d[7:0]};
		@(negedge sys_clk);
		{data_low_wr, data_mid_wr, sfr_wdata} = {2'b01, d[15:8]};
		@(negedge sys_clk);
		{data_mid_wr, data_high_wr, sfr_wdata} = {2'b01, d[23:16]};
		@(negedge sys_clk);
		{data_high_wr, pointer_wr, sfr_wdata} = {2'b01, ptr};
		@(negedge sys_clk);
		{pointer_wr, sfr_wdata} = {1'b0, ~ptr};
		// Core is slower than the host: settle before using the data bytes
		repeat (2) @(negedge sys_clk);
		rd = {indirect_data_high, indirect_data_mid, indirect_data_low};
	endtask
endmodule

/* File: sim/mcr_register_map_chk.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module mcr_register_map_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Host access
	input wire logic pointer_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] indirect_pointer_byte,
	input wire logic [7:0] indirect_data_low,
	input wire logic [7:0] indirect_data_mid,
	input wire logic [7:0] indirect_data_high,
	input wire logic access_busy,
	// Line timing and configuration
	input wire logic half_cycle_tick,
	input wire logic line_window_end,
	input wire logic [15:0] line_period_meas,
	input wire logic [15:0] line_rate_meas,
	input wire logic [7:0] basic_config_one,
	input wire logic [7:0] basic_config_two,
	input wire logic [15:0] sag_threshold
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire [23:0] rd_word = {indirect_data_high, indirect_data_mid, indirect_data_low};
	wire [6:0] ptr_addr = indirect_pointer_byte[6:0];
	sequence xfer_s(logic [7:0] p);
		access_busy && indirect_pointer_byte == p;
	endsequence
	sequence rd_s;
		access_busy && !indirect_pointer_byte[7];
	endsequence
	////////////////////////////////////////////////////////////////////////////
	busy_one_cycle_a: assert property (access_busy |=> !access_busy)
		else $error("busy longer than one cycle");
	ptr_take_a: assert property (pointer_wr && !access_busy |=>
		access_busy && indirect_pointer_byte == $past(sfr_wdata))
		else $error("pointer write not taken");
	one_byte_a: assert property (rd_s ##0 ptr_addr inside {[7'h0B:7'h10], 7'h13,
		7'h1B, [7'h24:7'h26], 7'h3D} |=> rd_word[23:8] == 16'h0000)
		else $error("upper bytes not cleared on one-byte read");
	gap_zero_a: assert property (rd_s ##0 ptr_addr inside {[7'h2B:7'h3C]} |=>
		rd_word == 24'h000000)
		else $error("gap address read not zero");
	sign_ext_a: assert property (rd_s ##0 ptr_addr inside {[7'h1C:7'h1F], 7'h22, 7'h23}
		|=> rd_word[23:12] == {12{rd_word[11]}})
		else $error("12-bit value not sign extended");
	rate_sel_a: assert property (xfer_s(8'h0A) |=> rd_word == {8'h00,
		$past(basic_config_two[1]) ? $past(line_rate_meas) : $past(line_period_meas)})
		else $error("period or rate selection wrong");
	sag_write_a: assert property (xfer_s(8'h94) |=>
		sag_threshold == {$past(indirect_data_mid), $past(indirect_data_low)})
		else $error("sag level write wrong");
	soft_reset_a: assert property (xfer_s(8'h8B) ##0 indirect_data_low[7] |=>
		##1 basic_config_one == 8'h06)
		else $error("soft reset did not restore config");
	window_end_a: assert property (line_window_end |-> $past(half_cycle_tick))
		else $error("window end without half cycle tick");
endmodule
bind mcr_metering_core_register_map mcr_register_map_chk chk_u (.sys_clk, .sys_rst, .pointer_wr,
	.sfr_wdata, .indirect_pointer_byte, .indirect_data_low, .indirect_data_mid,
	.indirect_data_high, .access_busy, .half_cycle_tick, .line_window_end, .line_period_meas,
	.line_rate_meas, .basic_config_one, .basic_config_two, .sag_threshold);

/* File: sim/test_metering_core_register_map.sv */
`timescale 1ns/1ns
module test_metering_core_register_map;
	typedef struct packed {logic [7:0] a; logic [23:0] r; logic [23:0] w; logic [23:0] e;} mcr_row_t;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic pointer_wr, data_low_wr, data_mid_wr, data_high_wr;
	logic [7:0] sfr_wdata, dlo, dmi, dhi;
	logic [3:0] fl = 4'h0;
	logic [23:0] rinc = 24'h000000, csmp = 24'h000000, rd;
	logic [15:0] vsmp = 16'h0000;
	wire [7:0] c_wav, c_nl, c_acc, c_ph, c_amp, c_cal, c_sag, c_adiv, c_rdiv;
	wire [11:0] c_zx, c_wg;
	wire [15:0] c_lc, c_rofs, c_den2;
	wire cv = |csmp;
	wire vv = |vsmp;
	int n_fail = 0, n_tests = 0, cyc = 0;
	mcr_row_t rows [20] = '{80'h0B_000006_000055_000055, 80'h0C_000040_FFFF3C_00003C,
		80'h0D_000000_0000A5_0000A5, 80'h0E_000000_00005A_00005A,
		80'h0F_000000_0000C3_0000C3, 80'h10_000040_0000FF_0000FF,
		80'h11_000FFF_00F123_000123, 80'h12_00FFFF_000002_000002,
		80'h13_0000FF_000001_000001, 80'h14_000000_000155_000155,
		80'h15_00FFFF_001234_001234, 80'h1B_000000_000007_000007,
		80'h1D_000000_000800_FFF800, 80'h21_000000_008000_FF8000,
		80'h24_000000_000081_000081, 80'h2A_00003F_001234_001234,
		80'h3D_000000_000033_000033, 80'h30_000000_123456_000000,
		80'h07_000000_123456_000000, 80'h0A_001111_00FFFF_001111};
	logic [67:0] stim [7] = '{68'h6_000003_000000_0000, 68'h0_000000_000000_0000,
		68'h6_000004_000000_0000, 68'h5_000005_123456_BEEF, 68'h4_000005_000100_0001,
		68'h4_000005_000000_0000, 68'h0_000000_000000_0000};
	logic [31:0] rb [14] = '{32'h06_000007, 32'h04_000016, 32'h04_000016, 32'h05_000016,
		32'h04_000000, 32'h07_000007, 32'h08_000007, 32'h07_000000, 32'h17_123456,
		32'h18_123456, 32'h17_000000, 32'h19_00BEEF, 32'h1A_00BEEF, 32'h19_000000};
	mcr_metering_core_register_map dut_u (.sys_clk, .sys_rst, .pointer_wr, .data_low_wr,
		.data_mid_wr, .data_high_wr, .sfr_wdata, .indirect_pointer_byte(), .indirect_data_low(dlo),
		.indirect_data_mid(dmi), .indirect_data_high(dhi), .access_busy(),
		.reactive_energy_valid(fl[2]), .reactive_energy_inc(rinc), .apparent_energy_valid(fl[0]),
		.apparent_energy_inc(24'h000007), .half_cycle_tick(fl[1]), .line_period_meas(16'h1111),
		.line_rate_meas(16'h2222), .current_peak_valid(cv), .current_peak_sample(csmp),
		.voltage_peak_valid(vv), .voltage_peak_sample(vsmp), .line_window_end(),
		.basic_config_one(), .basic_config_two(), .waveform_select_cfg(c_wav),
		.no_load_threshold_cfg(c_nl), .accumulation_cfg(c_acc), .phase_calibration(c_ph),
		.zero_cross_timeout(c_zx), .line_cycle_count(c_lc), .sag_half_cycle_count(c_sag),
		.sag_threshold(), .current_peak_threshold(), .voltage_peak_threshold(),
		.input_amp_gain(c_amp), .second_current_match_gain(), .active_power_gain(c_wg),
		.reactive_power_gain(), .apparent_power_gain(), .active_power_offset(),
		.reactive_power_offset(c_rofs), .current_rms_offset(), .voltage_rms_offset(),
		.active_energy_divider(c_adiv), .reactive_energy_divider(c_rdiv),
		.apparent_energy_divider(), .pulse_out1_numerator(), .pulse_out1_denominator(),
		.pulse_out2_numerator(), .pulse_out2_denominator(c_den2), .calibration_select(c_cal));
	mcr_host_model host_u (.sys_clk, .indirect_data_low(dlo), .indirect_data_mid(dmi),
		.indirect_data_high(dhi), .pointer_wr, .data_low_wr, .data_mid_wr, .data_high_wr, .sfr_wdata);
	////////////////////////////////////////////////////////////////////////////
	always #4 sys_clk = ~sys_clk;
	task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(negedge sys_clk);
		sys_rst = 1'b0;
		// Stale data bytes on reads expose any byte a read fails to update
		foreach (rows[i]) begin
			host_u.access(rows[i].a, 24'hA5A5A5, rd);
			chk("reset value", rows[i].r, rd);
			host_u.access(rows[i].a | 8'h80, rows[i].w, rd);
			host_u.access(rows[i].a, 24'hA5A5A5, rd);
			chk("readback", rows[i].e, rd);
		end
		chk("cfg a", {8'hA5, 8'h5A, 8'hC3}, {c_wav, c_nl, c_acc});
		chk("cfg b", {8'hFF, 8'h07, 8'h33}, {c_ph, c_amp, c_cal});
		chk("cfg c", {12'h123, 12'h800}, {c_zx, c_wg});
		chk("cfg d", {8'h01, 16'h0002}, {c_sag, c_lc});
		chk("cfg e", {8'h81, 16'h8000}, {c_adiv, c_rofs});
		chk("cfg f", {8'h00, 16'h1234}, {c_rdiv, c_den2});
		// Two half cycles close a window, then energy and peaks
		foreach (stim[i]) begin
			@(negedge sys_clk);
			{fl, rinc, csmp, vsmp} = stim[i];
		end
		foreach (rb[i]) begin
			host_u.access(rb[i][31:24], 24'hA5A5A5, rd);
			chk("accumulator", rb[i][23:0], rd);
		end
		host_u.access(8'h8C, 24'h000042, rd);
		host_u.access(8'h0A, 24'hA5A5A5, rd);
		chk("rate select", 24'h002222, rd);
		host_u.access(8'h8B, 24'h000080, rd);
		host_u.access(8'h12, 24'hA5A5A5, rd);
		chk("soft reset", 24'h00FFFF, rd);
		// Mid-run reset must restore a written default
		host_u.access(8'h93, 24'h000011, rd);
		sys_rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		sys_rst = 1'b0;
		host_u.access(8'h13, 24'hA5A5A5, rd);
		chk("hard reset", 24'h0000FF, rd);
		report_and_stop();
	end
endmodule
